// ==== spsk_pkg.sv ====
// Package: constants for the page context stack
package spsk_pkg;
   // Register addresses, all pages
   localparam logic [7:0] ADDR_ACTIVE_PAGE = 8'h84;
   localparam logic [7:0] ADDR_STACK_SECOND = 8'h85;
   localparam logic [7:0] ADDR_STACK_BOTTOM = 8'h86;
   // Control register address and page
   localparam logic [7:0] ADDR_AUTOPAGE_CTRL = 8'h96;
   localparam logic [7:0] PAGE_AUTOPAGE_CTRL = 8'h0f;
   // Field positions
   localparam int AUTOPAGE_ENABLE_BIT = 0;
   // Reset values
   localparam logic [7:0] RST_PAGE_ENTRY = 8'h00;
   localparam logic [7:0] RST_AUTOPAGE_CTRL = 8'h01;
   // Stack depth
   localparam int STACK_DEPTH = 3;
endpackage

// ==== spsk_entry.sv ====
// One byte-wide entry of the page stack
`timescale 1ns/1ps
module spsk_entry #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Controls
   input wire logic shift_in,
   input wire logic [WIDTH-1:0] shift_data_in,
   input wire logic write_in,
   input wire logic [WIDTH-1:0] write_data_in,
   // Stored value
   output logic [WIDTH-1:0] value_out
);
   logic [WIDTH-1:0] value_ff;
   logic [WIDTH-1:0] nxt_value;

   // Stack movement first, then software write overrides
   assign nxt_value = write_in ? write_data_in : (shift_in ? shift_data_in : value_ff);

   // Entry register
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         value_ff <= WIDTH'(spsk_pkg::RST_PAGE_ENTRY);
      end
      else
      begin
         value_ff <= nxt_value;
      end
   end

   assign value_out = value_ff;
endmodule // spsk_entry

// ==== spsk_stack.sv ====
// Page context stack with automatic paging on interrupts
`timescale 1ns/1ps

// Overview
// The stack holds three page bytes. The top entry is the active page and
// drives the register decoder of the whole core, so every register access
// outside the all-page group depends on it.
//
// Interrupt entry pushes: top moves to second, second moves to bottom and
// the bottom byte is lost. The top is then loaded with the page of the
// interrupting source. Interrupt return pops: second moves to top and bottom
// moves to second, while the bottom keeps its value.
//
// Software reaches all three entries at fixed addresses on every page. Such
// accesses never push or pop. A software write that meets a strobe in the
// same cycle wins for the entry it targets, the other entries still shift.
// This lets a handler rewrite the return page even while a nested event
// lands.
//
// The control register sits on one page only. Its enable bit gates both
// push and pop, so with paging off the stack is a plain set of registers.
// A return that coincides with an entry is dropped; the core never issues
// both for one instruction, and the push must not be lost.
//
// Read data is registered and stands for one cycle after the read strobe.
// Idle and unmapped cycles return zero so that an OR-bus can be used.
module spsk_stack #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Interrupt sequencer events
   input wire logic irq_entry_in,
   input wire logic [WIDTH-1:0] irq_page_in,
   input wire logic return_from_interrupt_in,
   // Register bus
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_hit_out,
   // Active page to the register decoder
   output logic [WIDTH-1:0] active_page_select_out,
   output logic autopage_enable_out
);
   // Elaboration checks: the read mux and the control byte assume byte entries
   if (WIDTH != 8)
   begin : g_width_check
      $error("spsk_stack supports only byte-wide entries");
   end

   // The shift network below is written for exactly three entries
   if (spsk_pkg::STACK_DEPTH != 3)
   begin : g_depth_check
      $error("spsk_stack shift network needs a three-entry stack");
   end

   // The enable bit must sit inside the byte-wide control register
   if (spsk_pkg::AUTOPAGE_ENABLE_BIT > 7)
   begin : g_field_check
      $error("spsk_stack enable bit lies outside the control byte");
   end

   logic autopage_enable_ff;
   logic nxt_autopage_enable;
   logic [WIDTH-1:0] entry_val [spsk_pkg::STACK_DEPTH];
   logic [WIDTH-1:0] shift_src [spsk_pkg::STACK_DEPTH];
   logic [WIDTH-1:0] entry_wdata [spsk_pkg::STACK_DEPTH];
   logic entry_wr [spsk_pkg::STACK_DEPTH];
   logic [7:0] reg_rdata_ff;
   logic [7:0] nxt_rdata;
   logic do_push;
   logic do_pop;
   logic shift_any;
   logic sel_top;
   logic sel_second;
   logic sel_bottom;
   logic sel_ctrl;
   logic page_is_ctrl;

   // Per-register write strobes
   logic wr_top;
   logic wr_second;
   logic wr_bottom;
   logic wr_ctrl;

   // Per-register read strobes
   logic rd_top;
   logic rd_second;
   logic rd_bottom;
   logic rd_ctrl;

   // Read terms, one per register
   logic [7:0] ctrl_rdata;
   logic [7:0] rdata_top;
   logic [7:0] rdata_second;
   logic [7:0] rdata_bottom;
   logic [7:0] rdata_ctrl;

   // Address decode; stack entries ignore the active page
   assign sel_top = (reg_addr_in == spsk_pkg::ADDR_ACTIVE_PAGE);
   assign sel_second = (reg_addr_in == spsk_pkg::ADDR_STACK_SECOND);
   assign sel_bottom = (reg_addr_in == spsk_pkg::ADDR_STACK_BOTTOM);

   // Control register lives on one page only, so it also needs the active page
   assign page_is_ctrl = (entry_val[0] == WIDTH'(spsk_pkg::PAGE_AUTOPAGE_CTRL));
   assign sel_ctrl = (reg_addr_in == spsk_pkg::ADDR_AUTOPAGE_CTRL) && page_is_ctrl;
   assign reg_hit_out = sel_top | sel_second | sel_bottom | sel_ctrl;

   // Push and pop come only from the sequencer strobes
   assign do_push = irq_entry_in & autopage_enable_ff;
   assign do_pop = return_from_interrupt_in & autopage_enable_ff & ~irq_entry_in;
   assign shift_any = do_push | do_pop;

   // Shift sources per entry
   assign shift_src[0] = do_push ? irq_page_in : entry_val[1];
   assign shift_src[1] = do_push ? entry_val[0] : entry_val[2];
   assign shift_src[2] = do_push ? entry_val[1] : entry_val[2];

   // Software writes, applied after a simultaneous strobe
   assign wr_top = reg_wr_in & sel_top;
   assign wr_second = reg_wr_in & sel_second;
   assign wr_bottom = reg_wr_in & sel_bottom;
   assign wr_ctrl = reg_wr_in & sel_ctrl;
   assign entry_wr[0] = wr_top;
   assign entry_wr[1] = wr_second;
   assign entry_wr[2] = wr_bottom;

   // Read strobes; none of them reaches the shift controls
   assign rd_top = reg_rd_in & sel_top;
   assign rd_second = reg_rd_in & sel_second;
   assign rd_bottom = reg_rd_in & sel_bottom;
   assign rd_ctrl = reg_rd_in & sel_ctrl;
   assign entry_wdata[0] = reg_wdata_in[WIDTH-1:0];
   assign entry_wdata[1] = reg_wdata_in[WIDTH-1:0];
   assign entry_wdata[2] = reg_wdata_in[WIDTH-1:0];

   // Three stack entries
   genvar gi;
   generate
      for (gi = 0; gi < spsk_pkg::STACK_DEPTH; gi++)
      begin : g_entry
         spsk_entry #(
            .WIDTH(WIDTH)
         ) u_entry (
            .core_clk_in(core_clk_in),
            .reset_in(reset_in),
            .shift_in(shift_any),
            .shift_data_in(shift_src[gi]),
            .write_in(entry_wr[gi]),
            .write_data_in(entry_wdata[gi]),
            .value_out(entry_val[gi])
         );
      end
   endgenerate

   // Auto paging enable bit
   assign nxt_autopage_enable = wr_ctrl
      ? reg_wdata_in[spsk_pkg::AUTOPAGE_ENABLE_BIT] : autopage_enable_ff;

   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         autopage_enable_ff <= spsk_pkg::RST_AUTOPAGE_CTRL[spsk_pkg::AUTOPAGE_ENABLE_BIT];
      end
      else
      begin
         autopage_enable_ff <= nxt_autopage_enable;
      end
   end

   // Control register read value; reserved bits read as zero
   assign ctrl_rdata = 8'(autopage_enable_ff) << spsk_pkg::AUTOPAGE_ENABLE_BIT;

   // Per-register read terms; the selects are exclusive, so at most one is set
   assign rdata_top = rd_top ? 8'(entry_val[0]) : 8'h00;
   assign rdata_second = rd_second ? 8'(entry_val[1]) : 8'h00;
   assign rdata_bottom = rd_bottom ? 8'(entry_val[2]) : 8'h00;
   assign rdata_ctrl = rd_ctrl ? ctrl_rdata : 8'h00;

   // Read mux; idle and unmapped cycles give zero
   assign nxt_rdata = rdata_top | rdata_second | rdata_bottom | rdata_ctrl;

   // Read data register, valid the cycle after the read strobe
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         reg_rdata_ff <= 8'h00;
      end
      else
      begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_out = reg_rdata_ff;
   assign active_page_select_out = entry_val[0];
   assign autopage_enable_out = autopage_enable_ff;
endmodule // spsk_stack

// ==== spsk_asserts.sv ====
// Port checker for the page stack
`timescale 1ns/1ps
module spsk_asserts (
   // Observed ports
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic irq_entry_in,
   input wire logic return_from_interrupt_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic reg_hit_out,
   input wire logic autopage_enable_out,
   input wire logic [7:0] irq_page_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [7:0] active_page_select_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // Event decode
   wire logic [7:0] top = active_page_select_out;
   wire logic top_wr = reg_wr_in && reg_addr_in == 8'h84;
   wire logic push = irq_entry_in && autopage_enable_out && !top_wr;
   wire logic still = !top_wr && (!autopage_enable_out || !irq_entry_in && !return_from_interrupt_in);
   property p_wr; top_wr |=> top == $past(reg_wdata_in); endproperty
   a_wr: assert property (p_wr) else $error("top write lost");
   property p_push; push |=> top == $past(irq_page_in); endproperty
   a_push: assert property (p_push) else $error("push page wrong");
   property p_still; still |=> $stable(top); endproperty
   a_still: assert property (p_still) else $error("top moved");
   property p_rd; reg_rd_in && reg_addr_in == 8'h84 |=> reg_rdata_out == $past(top); endproperty
   a_rd: assert property (p_rd) else $error("top read wrong");
   property p_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("idle data");
   property p_unm; reg_rd_in && !reg_hit_out |=> reg_rdata_out == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unmapped data");
   property p_hit; reg_hit_out == (reg_addr_in inside {8'h84, 8'h85, 8'h86}
      || reg_addr_in == 8'h96 && top == 8'h0f); endproperty
   a_hit: assert property (p_hit) else $error("decode wrong");
   property p_rst; $fell(reset_in) |-> top == 8'h00 && autopage_enable_out; endproperty
   a_rst: assert property (p_rst) else $error("reset values");
endmodule // spsk_asserts
bind spsk_stack spsk_asserts u_chk (.*);

// ==== spsk_core_model.sv ====
// Core sequencer model making one-cycle strobes
`timescale 1ns/1ps
module spsk_core_model (
   // Clock and requests from the bench
   input wire logic core_clk_in,
   input wire logic entry_req_in,
   input wire logic return_req_in,
   input wire logic [7:0] page_req_in,
   // Strobes to the stack
   output logic entry_out = 1'b0,
   output logic return_out = 1'b0,
   output logic [7:0] page_out = 8'h00
);
   // Strobes last one cycle; page is scrambled when not qualified
   always @(posedge core_clk_in)
   begin
      entry_out <= entry_req_in;
      return_out <= return_req_in;
      page_out <= entry_req_in ? page_req_in : ~page_out;
   end
endmodule // spsk_core_model

// ==== test_spsk_stack.sv ====
// Testbench for the page stack
`timescale 1ns/1ps
module test_spsk_stack;
   logic core_clk_in = 1'b0, reset_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, ent = 1'b0;
   logic ret = 1'b0, irq_entry_in, return_from_interrupt_in, reg_hit_out, autopage_enable_out;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, pg = 8'h00, irq_page_in;
   logic [7:0] reg_rdata_out, active_page_select_out;
   int bad_count = 0, checked = 0;
   spsk_core_model core (.core_clk_in, .entry_req_in(ent), .return_req_in(ret),
      .page_req_in(pg), .entry_out(irq_entry_in), .return_out(return_from_interrupt_in),
      .page_out(irq_page_in));
   spsk_stack dut (.*);
   // Clock
   initial forever #25 core_clk_in = ~core_clk_in;
   task go; @(posedge core_clk_in); #1; endtask
   task chk(string n, logic [7:0] e, g);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(logic [7:0] a, d); go; reg_addr_in = a; reg_wdata_in = d; reg_wr_in = 1; go; reg_wr_in = 0; endtask
   task rd(logic [7:0] a, e); go; reg_addr_in = a; reg_rd_in = 1; go; chk("rdata", e, reg_rdata_out); reg_rd_in = 0; endtask
   task irq(logic [7:0] p); go; ent = 1; pg = p; go; ent = 0; endtask
   task rt; go; ret = 1; go; ret = 0; endtask
   task final_report;
      if (bad_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #40000;
      bad_count++;
      final_report;
   end
   // Main sequence
   initial
   begin
      repeat (20) @(posedge core_clk_in);
      #1 reset_in = 0;
      chk("enable", 8'h01, {7'h00, autopage_enable_out});
      rd(8'h85, 8'h00);
      rd(8'h86, 8'h00);
      wr(8'h84, 8'h0f);
      rd(8'h96, 8'h01);
      chk("hit", 8'h01, {7'h00, reg_hit_out});
      irq(8'h02);
      rd(8'h85, 8'h0f);
      irq(8'h00);
      rd(8'h86, 8'h0f);
      wr(8'h86, 8'h33);
      rd(8'h86, 8'h33);
      rd(8'h85, 8'h02);
      rt;
      rd(8'h84, 8'h02);
      rd(8'h85, 8'h33);
      wr(8'h85, 8'h44);
      rt;
      rd(8'h84, 8'h44);
      rd(8'h80, 8'h00);
      chk("hit", 8'h00, {7'h00, reg_hit_out});
      wr(8'h84, 8'h0f);
      wr(8'h96, 8'h00);
      chk("enable", 8'h00, {7'h00, autopage_enable_out});
      irq(8'h05);
      rt;
      rd(8'h96, 8'h00);
      chk("top", 8'h0f, active_page_select_out);
      wr(8'h85, 8'h5a);
      go;
      reset_in = 1;
      go;
      reset_in = 0;
      chk("top", 8'h00, active_page_select_out);
      chk("enable", 8'h01, {7'h00, autopage_enable_out});
      rd(8'h85, 8'h00);
      final_report;
   end
endmodule // test_spsk_stack
